// ### design/urx_fifo.sv
/*
 * Synchronous FIFO with parameter width and depth, valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
module urx_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic flush_done
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign flush_done = 1'b0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge pclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule : urx_fifo

// ### design/urx_pkg.sv
/*
 * Package for the receive status, break and baud generator block:
 * register offsets, field positions, reset values and state types.
 * Assumes a 32-bit APB register bus, one aligned word per register.
 */
package urx_pkg;
	localparam logic [7:0] OFF_LINE_STATUS = 8'h00;
	localparam logic [7:0] OFF_FRAME_CONFIG = 8'h04;
	localparam logic [7:0] OFF_BAUD_DIVISOR = 8'h08;
	localparam logic [7:0] OFF_RX_DATA = 8'h0C;
	localparam logic [7:0] OFF_CONTROL = 8'h10;

	// line status fields
	localparam int POS_DATA_AVAIL = 0;
	localparam int POS_FRAMING = 2;
	localparam int POS_PARITY = 3;
	localparam int POS_IDLE = 4;
	localparam int POS_ADDR_DETECT = 5;
	localparam int POS_RX_ISEL = 6;
	// frame config fields
	localparam int POS_STOP_SEL = 0;
	localparam int POS_PARITY_DATA_SELECT_LO = 1;
	localparam int POS_LOOPBACK = 6;
	localparam int POS_RX_IE = 7;
	// received data word fields
	localparam int POS_NINTH = 8;
	localparam int POS_WORD_FRAMING_ERROR_FLAG = 9;
	localparam int POS_WORD_PARITY_ERROR_FLAG = 10;

	localparam logic [15:0] RST_FRAME_CONFIG = 16'h0000;
	localparam logic [15:0] RST_BAUD_DIVISOR = 16'h0000;
	localparam logic [1:0] RST_CONTROL = 2'h0;

	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] SAMPLE_MID = 4'h7;
	localparam int BREAK_BIT_TIMES = 13;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 11;

	// parity/data select encodings
	localparam logic [1:0] PD_8N = 2'h0;
	localparam logic [1:0] PD_8E = 2'h1;
	localparam logic [1:0] PD_8O = 2'h2;
	localparam logic [1:0] PD_9N = 2'h3;

	typedef enum logic [2:0] {
		URX_IDLE,
		URX_START,
		URX_DATA,
		URX_PARITY,
		URX_STOP,
		URX_WAIT_HIGH
	} urx_state_type;
endpackage : urx_pkg

// ### design/urx_top.sv
/*
 * Receive side of an asynchronous serial port: baud generator, receiver with
 * framing, parity and break handling, address detect, loopback, receive FIFO
 * and an APB slave for the registers.
 * Assumes pclk is the instruction clock; the receive pin is asynchronous.
 */
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: a zero where a stop bit belongs sets the framing error flag.
// R2: with two stop bits both must be one, else framing error.
// R3: framing error is read-only, carried with each word, cleared by reset.
// R4: wrong parity in parity modes sets the parity error flag, buffered too.
// R5: idle flag low from start detection to stop completion, else high; after a non-break framing error it stays low until the line is high.
// R6: bit count per character comes from parity/data select and stop select.
// R7: long break ends after programmed length with zeros, framing error, idle.
// R8: after a bad stop bit wait for high line before seeking a start.
// R9: break stored as zero word with framing error; reception blocked until high.
// R10: address detect with 9-bit data marks ninth-bit-one words as addresses.
// R11: address detect ignores interrupt select; interrupt on every ninth-bit word.
// R12: loopback feeds transmit output to receiver; external pin ignored.
// R13: software configures mode, then loopback, then enables transmission.
// R14: baud divisor is a 16-bit read/write register, any value.
// R15: bit rate is clock divided by sixteen times divisor plus one.
// R16: divisor reloads a down-counter giving a sixteen-times sampling tick.
module urx_top
	import urx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_receive_pin,
	input wire logic tx_line_out,
	output logic serial_transmit_pin,
	output logic rx_interrupt
);
	//////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] uart_frame_config;
	logic [15:0] baud_divisor;
	logic address_detect_enable;
	logic receive_interrupt_select;
	logic [15:0] next_uart_frame_config;
	logic [15:0] next_baud_divisor;
	logic next_address_detect_enable;
	logic next_receive_interrupt_select;
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign addr_ok = (paddr == OFF_LINE_STATUS) || (paddr == OFF_FRAME_CONFIG) ||
		(paddr == OFF_BAUD_DIVISOR) || (paddr == OFF_RX_DATA);
	assign pslverr = psel && penable && !addr_ok;

	always_comb
	begin
		next_uart_frame_config = uart_frame_config;
		next_baud_divisor = baud_divisor;
		next_address_detect_enable = address_detect_enable;
		next_receive_interrupt_select = receive_interrupt_select;
		if (wr_en && paddr == OFF_FRAME_CONFIG)
			next_uart_frame_config = pwdata[15:0];
		if (wr_en && paddr == OFF_BAUD_DIVISOR)
			next_baud_divisor = pwdata[15:0]; // R14
		if (wr_en && paddr == OFF_LINE_STATUS)
		begin
			next_address_detect_enable = pwdata[POS_ADDR_DETECT];
			next_receive_interrupt_select = pwdata[POS_RX_ISEL];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			uart_frame_config <= RST_FRAME_CONFIG;
			baud_divisor <= RST_BAUD_DIVISOR;
			address_detect_enable <= RST_CONTROL[0];
			receive_interrupt_select <= RST_CONTROL[1];
		end
		else
		begin
			uart_frame_config <= next_uart_frame_config;
			baud_divisor <= next_baud_divisor;
			address_detect_enable <= next_address_detect_enable;
			receive_interrupt_select <= next_receive_interrupt_select;
		end
	end

	logic [1:0] parity_data_select;
	logic stop_bits_select;
	logic loopback_enable;
	logic rx_int_enable;
	assign parity_data_select = uart_frame_config[POS_PARITY_DATA_SELECT_LO +: 2];
	assign stop_bits_select = uart_frame_config[POS_STOP_SEL];
	assign loopback_enable = uart_frame_config[POS_LOOPBACK];
	assign rx_int_enable = uart_frame_config[POS_RX_IE];
	assign serial_transmit_pin = tx_line_out; // R12

	//////////////////////////////////////////////////////////////////////////
	// baud tick
	logic [15:0] baud_count;
	logic [15:0] next_baud_count;
	logic os_tick;
	assign os_tick = (baud_count == 16'h0000);

	always_comb
	begin
		next_baud_count = os_tick ? baud_divisor : baud_count - 16'h0001; // R15 R16
		// a new divisor restarts the count, else an old large divisor delays it
		if (wr_en && paddr == OFF_BAUD_DIVISOR)
			next_baud_count = 16'h0000; // R14
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			baud_count <= 16'h0000;
		else
			baud_count <= next_baud_count;
	end

	//////////////////////////////////////////////////////////////////////////
	// line input: synchroniser then loopback select
	logic pin_meta;
	logic pin_sync;
	logic rx_line;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end
		else
		begin
			pin_meta <= serial_receive_pin;
			pin_sync <= pin_meta;
		end
	end
	assign rx_line = loopback_enable ? tx_line_out : pin_sync; // R12

	//////////////////////////////////////////////////////////////////////////
	// receiver
	urx_state_type state;
	urx_state_type next_state;
	logic [3:0] os_count;
	logic [3:0] next_os_count;
	logic [3:0] bit_index;
	logic [3:0] next_bit_index;
	logic [8:0] shift;
	logic [8:0] next_shift;
	logic stop_index;
	logic next_stop_index;
	logic frame_bad;
	logic next_frame_bad;
	logic parity_bad;
	logic next_parity_bad;
	logic all_zero;
	logic next_all_zero;
	logic receiver_idle_flag;
	logic next_receiver_idle_flag;
	logic push_valid;
	logic push_ready;
	logic [FIFO_WIDTH-1:0] push_data;
	logic sample_point;
	logic [3:0] data_bits;
	logic parity_on;

	assign sample_point = os_tick && (os_count == SAMPLE_MID);
	assign data_bits = (parity_data_select == PD_9N) ? 4'h9 : 4'h8; // R6
	assign parity_on = (parity_data_select == PD_8E) || (parity_data_select == PD_8O); // R6

	function automatic logic parity_fail(input logic [1:0] pd, input logic [7:0] d, input logic p);
		parity_fail = (pd == PD_8E) ? (^d) != p : (~^d) != p;
	endfunction : parity_fail

	always_comb
	begin
		next_state = state;
		next_os_count = os_tick ? os_count + 4'h1 : os_count;
		next_bit_index = bit_index;
		next_shift = shift;
		next_stop_index = stop_index;
		next_frame_bad = frame_bad;
		next_parity_bad = parity_bad;
		next_all_zero = all_zero;
		next_receiver_idle_flag = receiver_idle_flag;
		push_valid = 1'b0;
		push_data = {parity_bad, frame_bad, shift};
		unique case (state)
			URX_IDLE:
			begin
				if (!rx_line)
				begin
					next_state = URX_START;
					next_os_count = 4'h0;
					next_receiver_idle_flag = 1'b0; // R5
				end
			end
			URX_START:
			begin
				if (sample_point)
				begin
					// next mid-bit sample falls a full sixteen ticks later
					next_os_count = SAMPLE_MID + 4'h1; // R16
					if (rx_line)
					begin
						next_state = URX_IDLE;
						next_receiver_idle_flag = 1'b1;
					end
					else
					begin
						next_state = URX_DATA;
						next_bit_index = 4'h0;
						next_shift = 9'h000;
						next_frame_bad = 1'b0;
						next_parity_bad = 1'b0;
						next_all_zero = 1'b1;
					end
				end
				else if (os_tick && os_count == 4'hF)
					next_os_count = 4'h0;
			end
			URX_DATA:
			begin
				if (sample_point)
				begin
					next_shift[bit_index] = rx_line;
					next_all_zero = all_zero && !rx_line;
					next_bit_index = bit_index + 4'h1;
					if (bit_index + 4'h1 == data_bits)
						next_state = parity_on ? URX_PARITY : URX_STOP;
					next_stop_index = 1'b0;
				end
			end
			URX_PARITY:
			begin
				if (sample_point)
				begin
					next_parity_bad = parity_fail(parity_data_select, shift[7:0], rx_line); // R4
					next_all_zero = all_zero && !rx_line;
					next_state = URX_STOP;
				end
			end
			URX_STOP:
			begin
				if (sample_point)
				begin
					if (!rx_line)
						next_frame_bad = 1'b1; // R1 R2
					if (stop_bits_select && !stop_index)
					begin
						next_stop_index = 1'b1; // R2
					end
					else
					begin
						// a zero stop closes the word now, break or not
						push_valid = 1'b1;
						push_data = {parity_bad, frame_bad || !rx_line, shift}; // R3 R4
						if (frame_bad || !rx_line)
						begin
							next_state = URX_WAIT_HIGH; // R8 R9
							// break: zero word, framing error, idle set
							if (all_zero)
							begin
								push_data = {1'b0, 1'b1, 9'h000}; // R7 R9
								next_receiver_idle_flag = 1'b1; // R7
							end
						end
						else
						begin
							next_state = URX_IDLE;
							next_receiver_idle_flag = 1'b1; // R5
						end
					end
				end
			end
			URX_WAIT_HIGH:
			begin
				if (rx_line)
				begin
					next_state = URX_IDLE; // R8 R9
					next_receiver_idle_flag = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= URX_IDLE;
			os_count <= 4'h0;
			bit_index <= 4'h0;
			shift <= 9'h000;
			stop_index <= 1'b0;
			frame_bad <= 1'b0;
			parity_bad <= 1'b0;
			all_zero <= 1'b0;
			receiver_idle_flag <= 1'b1;
		end
		else
		begin
			state <= next_state;
			os_count <= next_os_count;
			bit_index <= next_bit_index;
			shift <= next_shift;
			stop_index <= next_stop_index;
			frame_bad <= next_frame_bad;
			parity_bad <= next_parity_bad;
			all_zero <= next_all_zero;
			receiver_idle_flag <= next_receiver_idle_flag;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// receive FIFO and read side
	logic head_valid;
	logic head_pop;
	logic [FIFO_WIDTH-1:0] head_data;
	logic is_nine;

	assign head_pop = rd_en && paddr == OFF_RX_DATA;
	assign is_nine = (parity_data_select == PD_9N);

	urx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(head_valid),
		.out_ready(head_pop),
		.out_data(head_data),
		.flush_done()
	);

	logic receive_data_available;
	logic framing_error_flag;
	logic parity_error_flag;
	logic ninth_received_bit;
	logic overrun_flag;
	assign receive_data_available = head_valid;
	assign framing_error_flag = head_valid && head_data[POS_WORD_FRAMING_ERROR_FLAG]; // R3
	assign parity_error_flag = head_valid && head_data[POS_WORD_PARITY_ERROR_FLAG]; // R4
	assign ninth_received_bit = head_valid && is_nine && head_data[POS_NINTH];
	assign overrun_flag = push_valid && !push_ready;

	// interrupt: address mode fires only on ninth-bit words, isel ignored
	always_comb
	begin
		if (address_detect_enable && is_nine)
			rx_interrupt = rx_int_enable && ninth_received_bit; // R10 R11
		else if (receive_interrupt_select)
			rx_interrupt = rx_int_enable && head_valid;
		else
			rx_interrupt = rx_int_enable && head_valid && receiver_idle_flag;
	end

	logic [31:0] next_prdata;
	always_comb
	begin
		next_prdata = 32'h00000000;
		unique case (paddr)
			OFF_LINE_STATUS:
			begin
				next_prdata[POS_DATA_AVAIL] = receive_data_available;
				next_prdata[POS_FRAMING] = framing_error_flag;
				next_prdata[POS_PARITY] = parity_error_flag;
				next_prdata[POS_IDLE] = receiver_idle_flag;
				next_prdata[POS_ADDR_DETECT] = address_detect_enable;
				next_prdata[POS_RX_ISEL] = receive_interrupt_select;
				next_prdata[1] = overrun_flag;
			end
			OFF_FRAME_CONFIG: next_prdata[15:0] = uart_frame_config;
			OFF_BAUD_DIVISOR: next_prdata[15:0] = baud_divisor; // R14
			OFF_RX_DATA:
			begin
				next_prdata[8:0] = head_valid ? head_data[8:0] : 9'h000;
				if (!is_nine)
					next_prdata[8] = 1'b0;
			end
			default: next_prdata = 32'h00000000;
		endcase
	end
	assign prdata = next_prdata;
endmodule : urx_top

// ### testbench/uart_receive_status_and_baud_bench.sv
/*
 * self-checking bench: apb master, line model, loopback routing.
 * assumes urx_top, its monitor and the line model are compiled first.
 */
module uart_receive_status_and_baud_bench
	import urx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, stp, irq, mline, err;
	logic route = 1'b0;
	logic [8:0] d;
	logic [8:0] q[$];
	int num_errors = 0;
	int checks = 0;
	int bt = 32;
	int i, pd, st;

	always #10 pclk = ~pclk;

	urx_top urx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_receive_pin(route ? ~mline : mline), .tx_line_out(route ? mline : 1'b1),
		.serial_transmit_pin(stp), .rx_interrupt(irq));
	urx_line_model urx_line_model_inst (.pclk(pclk), .line(mline));

	////////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task check(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check

	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			num_errors++;
			$display("unexpected at %0t: no pready", $time);
			close_out();
		end
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] v);
		apb(a, 1'b1, v);
	endtask : wr

	task rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h0);
	endtask : rd

	task cfg(input logic [1:0] p, input logic s, input logic [7:0] x);
		wr(OFF_FRAME_CONFIG, {24'h0, x | {5'h0, p, s}});
	endtask : cfg

	task frame(input logic [8:0] v, input logic [1:0] p, input logic s, input logic bp, input int bs);
		urx_line_model_inst.send(v, p == PD_9N ? 9 : 8, p == PD_8E ? 1 : p == PD_8O ? 2 : 0, s ? 2 : 1, bp, bs, bt);
	endtask : frame

	task sta(input logic a, input logic f, input logic p);
		rd(OFF_LINE_STATUS);
		check(rv[POS_DATA_AVAIL], a);
		check(rv[POS_FRAMING], f);
		check(rv[POS_PARITY], p);
	endtask : sta

	function logic [8:0] expw(input logic [8:0] v, input logic [1:0] p);
		return p == PD_9N ? v : {1'b0, v[7:0]};
	endfunction : expw

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hFF0D));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_FRAME_CONFIG);
		check(rv, {16'h0000, RST_FRAME_CONFIG});
		rd(OFF_LINE_STATUS);
		check(rv[POS_IDLE], 1'b1);
		wr(OFF_BAUD_DIVISOR, 32'h0000FFFF);
		rd(OFF_BAUD_DIVISOR);
		check(rv, 32'h0000FFFF);
		rd(OFF_CONTROL);
		check(err, 1'b1);
		wr(OFF_BAUD_DIVISOR, 32'h1);
		for (pd = 0; pd < 4; pd++)
			for (st = 0; st < 2; st++)
			begin
				d = 9'($urandom);
				cfg(2'(pd), st[0], 8'h00);
				frame(d, 2'(pd), st[0], 1'b0, -1);
				sta(1'b1, 1'b0, 1'b0);
				rd(OFF_RX_DATA);
				check(rv[8:0], expw(d, 2'(pd)));
			end
		cfg(PD_8O, 1'b0, 8'h00);
		frame(d, PD_8O, 1'b0, 1'b1, -1);
		sta(1'b1, 1'b0, 1'b1);
		rd(OFF_RX_DATA);
		cfg(PD_8N, 1'b0, 8'h00);
		frame(d, PD_8N, 1'b0, 1'b0, 0);
		urx_line_model_inst.drive(1'b1, bt);
		sta(1'b1, 1'b1, 1'b0);
		rd(OFF_RX_DATA);
		cfg(PD_8N, 1'b1, 8'h00);
		frame(d, PD_8N, 1'b1, 1'b0, 1);
		urx_line_model_inst.drive(1'b1, bt);
		frame(d, PD_8N, 1'b1, 1'b0, -1);
		sta(1'b1, 1'b1, 1'b0);
		rd(OFF_RX_DATA);
		sta(1'b1, 1'b0, 1'b0);
		frame(d, PD_8N, 1'b1, 1'b0, 0);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		sta(1'b0, 1'b0, 1'b0);
		wr(OFF_BAUD_DIVISOR, 32'h1);
		urx_line_model_inst.drive(1'b0, 15 * bt);
		rd(OFF_LINE_STATUS);
		check(rv[POS_IDLE], 1'b1);
		urx_line_model_inst.drive(1'b0, 5 * bt);
		urx_line_model_inst.drive(1'b1, 2 * bt);
		sta(1'b1, 1'b1, 1'b0);
		check(rv[POS_IDLE], 1'b1);
		rd(OFF_RX_DATA);
		check(rv[8:0], 9'h000);
		sta(1'b0, 1'b0, 1'b0);
		fork
			frame(d, PD_8N, 1'b0, 1'b0, -1);
			begin
				repeat (4 * bt) @(posedge pclk);
				rd(OFF_LINE_STATUS);
				check(rv[POS_IDLE], 1'b0);
			end
		join
		rd(OFF_RX_DATA);
		cfg(PD_9N, 1'b0, 8'h80);
		wr(OFF_LINE_STATUS, 32'h60);
		frame(9'h1A5, PD_9N, 1'b0, 1'b0, -1);
		repeat (2) @(negedge pclk);
		check(irq, 1'b1);
		rd(OFF_RX_DATA);
		check(rv[8:0], 9'h1A5);
		frame(9'h0A5, PD_9N, 1'b0, 1'b0, -1);
		repeat (2) @(negedge pclk);
		check(irq, 1'b0);
		rd(OFF_RX_DATA);
		wr(OFF_LINE_STATUS, 32'h0);
		cfg(PD_8N, 1'b0, 8'h00);
		cfg(PD_8N, 1'b0, 8'h40);
		route <= 1'b1;
		frame(d, PD_8N, 1'b0, 1'b0, -1);
		route <= 1'b0;
		cfg(PD_8N, 1'b0, 8'h00);
		rd(OFF_RX_DATA);
		check(rv[8:0], expw(d, PD_8N));
		wr(OFF_BAUD_DIVISOR, 32'h0);
		bt = 16;
		for (i = 0; i <= FIFO_DEPTH; i++)
		begin
			d = 9'($urandom);
			q.push_back(d);
			frame(d, PD_8N, 1'b0, 1'b0, -1);
		end
		for (i = 0; i < FIFO_DEPTH; i++)
		begin
			rd(OFF_RX_DATA);
			check(rv[8:0], expw(q[i], PD_8N));
		end
		sta(1'b0, 1'b0, 1'b0);
		close_out();
	end
endmodule : uart_receive_status_and_baud_bench

// ### testbench/urx_line_model.sv
/*
 * remote serial transmitter driving the receive line.
 * assumes callers enter its tasks right after a rising pclk edge.
 */
module urx_line_model (
	input wire logic pclk,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial line = 1'b1;

	task drive(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge pclk);
	endtask : drive

	// pk 0 none, 1 even, 2 odd; bs indexes a stop bit forced low
	task send(input logic [8:0] d, input int nb, input int pk, input int ns, input logic bp, input int bs,
		input int bt);
		logic p;
		int i;
		p = ((pk == 2) ? ~^d[7:0] : ^d[7:0]) ^ bp;
		drive(1'b0, bt);
		for (i = 0; i < nb; i++)
			drive(d[i], bt);
		if (pk != 0)
			drive(p, bt);
		for (i = 0; i < ns; i++)
			drive(i != bs, bt);
	endtask : send
endmodule : urx_line_model

// ### testbench/urx_top_monitor.sv
/*
 * port checker for the receive block.
 * assumes bind onto urx_top, one clock domain.
 */
module urx_top_monitor
	import urx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_receive_pin,
	input wire logic tx_line_out,
	input wire logic serial_transmit_pin,
	input wire logic rx_interrupt
);
	logic acc;
	logic rda;
	logic [15:0] ldiv, next_ldiv;
	logic [7:0] lcfg, next_lcfg;
	logic [2:0] lsta, next_lsta;
	assign acc = psel && penable;
	assign rda = acc && !pwrite;

	// shadow copies of the writable fields; lsta[2] marks a status write seen
	always_comb
	begin
		next_ldiv = ldiv;
		next_lcfg = lcfg;
		next_lsta = lsta;
		if (acc && pwrite && paddr == OFF_BAUD_DIVISOR)
			next_ldiv = pwdata[15:0];
		if (acc && pwrite && paddr == OFF_FRAME_CONFIG)
			next_lcfg = pwdata[7:0];
		if (acc && pwrite && paddr == OFF_LINE_STATUS)
			next_lsta = {1'b1, pwdata[6:5]};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ldiv <= RST_BAUD_DIVISOR;
			lcfg <= RST_FRAME_CONFIG[7:0];
			lsta <= 3'h0;
		end
		else
		begin
			ldiv <= next_ldiv;
			lcfg <= next_lcfg;
			lsta <= next_lsta;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_access: assert property (acc |-> pready) else $error("pready low in access");
	chk_err_unmapped: assert property (acc && paddr > OFF_RX_DATA |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (acc && paddr <= OFF_RX_DATA && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	chk_div_readback: assert property (rda && paddr == OFF_BAUD_DIVISOR |-> prdata == {16'h0000, ldiv})
		else $error("divisor read differs from last write");
	chk_cfg_readback: assert property (rda && paddr == OFF_FRAME_CONFIG |->
		prdata[7:6] == lcfg[7:6] && prdata[2:0] == lcfg[2:0] && prdata[31:16] == 16'h0) else $error("config read wrong");
	chk_sta_readback: assert property (rda && paddr == OFF_LINE_STATUS && lsta[2] |-> prdata[6:5] == lsta[1:0])
		else $error("status control bits wrong");
	chk_tx_follow: assert property (serial_transmit_pin == tx_line_out)
		else $error("transmit pin not following transmitter");
	chk_irq_enable: assert property (rx_interrupt |-> lcfg[POS_RX_IE])
		else $error("interrupt while disabled");
	chk_word_upper: assert property (rda && paddr == OFF_RX_DATA |-> prdata[31:11] == 21'h0)
		else $error("data word upper bits set");
endmodule : urx_top_monitor

bind urx_top urx_top_monitor urx_top_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_receive_pin(serial_receive_pin), .tx_line_out(tx_line_out), .serial_transmit_pin(serial_transmit_pin),
	.rx_interrupt(rx_interrupt));
